//--- frame_clock_gen.v
/*
 * hybrid-master frame clock generator counted in bit-clock ticks.
 * assumes bit_tick is a one-cycle pulse per bit clock, synchronous to sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module frame_clock_gen (
	input wire sys_clk,
	input wire rst_n,
	input wire enable,
	input wire bit_tick,
	input wire [10:0] high_count,
	input wire [11:0] period_count,
	output reg frame_clk
);
	reg [11:0] pos;
	// high for high_count+1 ticks of a period_count+1 tick frame
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pos <= 12'h000;
			frame_clk <= 1'b0;
		end
		else if (!enable)
		begin
			pos <= 12'h000;
			frame_clk <= 1'b0;
		end
		else if (bit_tick)
		begin
			frame_clk <= (pos <= {1'b0, high_count}); // R21
			if (pos >= period_count) // R22
				pos <= 12'h000;
			else
				pos <= pos + 12'h001;
		end
	end
endmodule
`default_nettype wire

//--- host_model.sv
/* host processor model: register strobes and bit clock ticks;
   assumes the bank samples requests on the rising edge of sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire sys_clk,
	input wire [7:0] reg_rdata,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output logic [15:0] reg_addr = 16'h0,
	output logic [7:0] reg_wdata = 8'h0,
	output logic latch_to_standby_supply = 1'b0,
	output logic bit_tick = 1'b0
);
	logic [1:0] cnt = 2'h0;
	logic pd_all = 1'b1;
	// bit clock never pauses, so a switch back always completes
	always @(negedge sys_clk)
	begin
		cnt <= cnt + 2'h1;
		bit_tick <= (cnt == 2'h3);
	end
	// released lines show the inverse, never the last value
	task wr(input logic [15:0] a, input logic [7:0] d);
		if (!pd_all && (a == 16'h1201 || a == 16'h1102 && d[4]))
			return;
		if (a == 16'h1101)
			pd_all = d[0];
		@(negedge sys_clk);
		if (a == 16'h1101 && d[0])
			latch_to_standby_supply = 1'b1;
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task rd(input logic [15:0] a, output logic [7:0] q);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge sys_clk);
		q = reg_rdata;
	endtask
endmodule
`default_nettype wire

//--- power_clock_chk.sv
/* assertion checker for the power and clock bank register port;
   assumes a bind to the bank top and 8-bit register data. */
`timescale 1ns/10ps
`default_nettype none
module power_clock_chk #(
	parameter MS_CYCLES = 40000,
	parameter PDN_SETTLE = 32,
	parameter SWITCH_TIME = 16
)(
	input wire sys_clk,
	input wire rst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire serial_input_power_up,
	input wire mixer_power_up,
	input wire headphone_power_up,
	input wire supply_monitor_power_up,
	input wire filter_cap_clamp,
	input wire master_clock_divider,
	input wire master_clock_source_select
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// a write is taken at one edge and shows at the outputs after it
	sequence wr_pd1; reg_wr && reg_addr == 16'h1101; endsequence
	sequence wr_pd2; reg_wr && reg_addr == 16'h1102; endsequence
	sequence wr_pd3; reg_wr && reg_addr == 16'h1103; endsequence
	sequence wr_src; reg_wr && reg_addr == 16'h1201; endsequence
	a_serial_path_power: assert property (wr_pd1 |=> serial_input_power_up
		== !($past(reg_wdata[6]) || $past(reg_wdata[0])))
		else $error("serial path power wrong after write");
	a_mixer_power: assert property (wr_pd1 |=> mixer_power_up
		== !($past(reg_wdata[5]) || $past(reg_wdata[0])))
		else $error("mixer power wrong after write");
	a_headphone_power: assert property (wr_pd1 |=> headphone_power_up
		== !($past(reg_wdata[3]) || $past(reg_wdata[0])))
		else $error("headphone power wrong after write");
	a_monitor_enable: assert property (wr_pd3 |=> supply_monitor_power_up
		== $past(reg_wdata[2]))
		else $error("supply monitor power wrong after write");
	a_clamp_follows: assert property (wr_pd2 |=> filter_cap_clamp
		== $past(reg_wdata[4]))
		else $error("filter clamp wrong after write");
	a_divider_follows: assert property (wr_src |=> master_clock_divider
		== $past(reg_wdata[1]))
		else $error("clock divider wrong after write");
	a_source_follows: assert property (wr_src |=> master_clock_source_select
		== $past(reg_wdata[0]))
		else $error("clock source wrong after write");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 16'h1300
		|=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind power_clock_control_bank power_clock_chk #(.MS_CYCLES(MS_CYCLES),
	.PDN_SETTLE(PDN_SETTLE), .SWITCH_TIME(SWITCH_TIME)) chk (.sys_clk,
	.rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
	.serial_input_power_up, .mixer_power_up, .headphone_power_up,
	.supply_monitor_power_up, .filter_cap_clamp, .master_clock_divider,
	.master_clock_source_select);
`default_nettype wire

//--- power_clock_control_bank.v
/*
 * power and clock control register bank with timeouts, power sequencing,
 * oscillator switch tracking, tip-sense debounce and frame clock generation.
 * assumes a simple synchronous register port driven by the control-port
 * front end, and a bit_tick pulse derived from the serial bit clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "power_clock_map.vh"
module power_clock_control_bank #(
	parameter MS_CYCLES = 40000,
	parameter PDN_SETTLE = `PDN_SETTLE_CYCLES,
	parameter SWITCH_TIME = `SWITCH_CYCLES
)(
	input wire sys_clk,
	input wire rst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire host_busy,
	input wire access_busy,
	output wire host_timeout,
	output wire access_timeout,
	input wire latch_to_standby_supply,
	input wire tip_raw,
	input wire bit_tick,
	input wire serial_input_interface,
	input wire hybrid_mode,
	output wire serial_input_power_up,
	output wire mixer_power_up,
	output wire headphone_power_up,
	output wire rate_converter_power_up,
	output wire supply_monitor_power_up,
	output wire filter_cap_clamp,
	output wire use_selected_clock,
	output wire master_clock_divider,
	output wire master_clock_source_select,
	output wire frame_clk,
	output wire standby_latch_error
);
	reg [7:0] timeout_cfg;
	reg [7:0] pdn1;
	reg [7:0] pdn2;
	reg [7:0] pdn3;
	reg clock_present;
	reg [7:0] tip_ctl;
	reg [7:0] mclk_src;
	reg [7:0] fpw_lo;
	reg [7:0] fpw_hi;
	reg [7:0] fper_lo;
	reg [7:0] fper_hi;
	reg rate_converter_bypass;
	reg power_down_complete;
	reg [7:0] settle;
	reg [1:0] oscillator_switch_state;
	reg oscillator_power_status;
	reg on_selected;
	reg [7:0] sw_count;
	reg tip_unplug_debounced;
	reg tip_plug_debounced;
	reg [31:0] dbnc_count;
	reg tip_seen;
	reg [31:0] host_limit;
	reg [31:0] dbnc_limit;
	reg [16:0] access_limit;
	localparam PD_ACTIVE = 3'h1;
	localparam PD_SETTLING = 3'h2;
	localparam PD_COMPLETE = 3'h4;
	reg [2:0] pd_state;
	wire global_power_down;
	wire tip_level;
	wire [2:0] dbnc_code;

	assign global_power_down = pdn1[`BIT_GLOBAL_POWER_DOWN];

	// write path; masks keep reserved bits at their defaults
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timeout_cfg <= `RST_TIMEOUT;
			pdn1 <= `RST_PDN1;
			pdn2 <= `RST_PDN2;
			pdn3 <= `RST_PDN3;
			clock_present <= 1'b0;
			tip_ctl <= `RST_TIP_CTL;
			mclk_src <= 8'h00;
			fpw_lo <= 8'h00;
			fpw_hi <= 8'h00;
			fper_lo <= `RST_FPER_LO;
			fper_hi <= 8'h00;
			rate_converter_bypass <= 1'b0;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`ADDR_TIMEOUT:
					timeout_cfg <= (reg_wdata & `MASK_TIMEOUT) |
						(`RST_TIMEOUT & ~`MASK_TIMEOUT); // R23
				`ADDR_PDN1:
					pdn1 <= (reg_wdata & `MASK_PDN1) |
						(`RST_PDN1 & ~`MASK_PDN1); // R23
				`ADDR_PDN2:
					pdn2 <= (reg_wdata & `MASK_PDN2) |
						(`RST_PDN2 & ~`MASK_PDN2); // R23
				`ADDR_PDN3:
					pdn3 <= reg_wdata & `MASK_PDN3;
				`ADDR_OSC_CTL:
					clock_present <= reg_wdata[0];
				`ADDR_TIP_CTL:
					tip_ctl <= reg_wdata & `MASK_TIP_CTL;
				`ADDR_MCLK_SRC:
					mclk_src <= reg_wdata & `MASK_MCLK_SRC;
				`ADDR_FPW_LO:
					fpw_lo <= reg_wdata;
				`ADDR_FPW_HI:
					fpw_hi <= reg_wdata & `MASK_FPW_HI;
				`ADDR_FPER_LO:
					fper_lo <= reg_wdata;
				`ADDR_FPER_HI:
					fper_hi <= reg_wdata & `MASK_FPER_HI;
				`ADDR_SRC_CTL:
					rate_converter_bypass <= reg_wdata[1];
				default:
					rate_converter_bypass <= rate_converter_bypass;
			endcase
		end
	end

	// read path; unmapped indices read zero
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				`ADDR_TIMEOUT: reg_rdata <= timeout_cfg;
				`ADDR_PDN1: reg_rdata <= pdn1;
				`ADDR_PDN2: reg_rdata <= pdn2;
				`ADDR_PDN3: reg_rdata <= pdn3;
				`ADDR_OSC_CTL: reg_rdata <= {7'h00, clock_present};
				`ADDR_OSC_STAT:
					reg_rdata <= {5'h00, oscillator_power_status,
						oscillator_switch_state}; // R14
				`ADDR_TIP_CTL: reg_rdata <= tip_ctl;
				`ADDR_TIP_STAT:
					reg_rdata <= {4'h0, tip_unplug_debounced,
						tip_plug_debounced, 2'h0}; // R17
				`ADDR_MCLK_SRC: reg_rdata <= mclk_src;
				`ADDR_FPW_LO: reg_rdata <= fpw_lo;
				`ADDR_FPW_HI: reg_rdata <= fpw_hi;
				`ADDR_FPER_LO: reg_rdata <= fper_lo;
				`ADDR_FPER_HI: reg_rdata <= fper_hi;
				`ADDR_SRC_CTL:
					reg_rdata <= {6'h04, rate_converter_bypass, 1'b0};
				`ADDR_POWER_DOWN_COMPLETE:
					reg_rdata <= {7'h00, power_down_complete}; // R04
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// timeout limits decoded from the select fields
	always @*
	begin
		host_limit = MS_CYCLES * (`MS_BASE << timeout_cfg[5:4]); // R01
		if (timeout_cfg[2:0] == 3'h7)
			access_limit = 17'h0ffff; // R02
		else
			access_limit = (17'h00008 << timeout_cfg[2:0]) - 17'h00001; // R02
	end

	// one counter per timeout; a disable bit keeps its counter disarmed
	timeout_counter #(.W(32)) host_to (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.arm(host_busy & ~timeout_cfg[6]), // R01
		.limit(host_limit),
		.expired(host_timeout)
	);

	timeout_counter #(.W(17)) access_to (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.arm(access_busy & ~timeout_cfg[3]), // R02
		.limit(access_limit),
		.expired(access_timeout)
	);

	// global power-down overrides the serial, mixer and headphone settings, and the rate converter unless its override bit is set
	assign serial_input_power_up = ~global_power_down &
		~pdn1[`BIT_SER_PDN]; // R03 R06
	assign mixer_power_up = ~global_power_down & ~pdn1[`BIT_MIX_PDN]; // R07
	assign headphone_power_up = ~global_power_down &
		~pdn1[`BIT_HEADPHONE_POWER_DOWN]; // R07
	assign rate_converter_power_up = pdn2[`BIT_RC_OVR] ?
		pdn2[`BIT_RC_ON] : // R10
		(~rate_converter_bypass & ~global_power_down &
		serial_input_interface); // R09
	assign supply_monitor_power_up = pdn3[`BIT_MON_EN]; // R11
	assign filter_cap_clamp = pdn2[`BIT_CLAMP]; // R08
	assign standby_latch_error = global_power_down & ~latch_to_standby_supply;
	assign master_clock_divider = mclk_src[1]; // R18
	assign master_clock_source_select = mclk_src[0]; // R20
	assign use_selected_clock = on_selected;

	// power-down sequence: the settle time lets analog blocks really stop
	// before the completion flag tells the host the bit clock may go
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pd_state <= PD_SETTLING;
			settle <= 8'h00;
			power_down_complete <= 1'b0;
		end
		else
		begin
			case (pd_state)
				PD_ACTIVE:
				begin
					power_down_complete <= 1'b0;
					if (global_power_down)
					begin
						pd_state <= PD_SETTLING;
						settle <= 8'h01;
					end
					else
						settle <= 8'h00;
				end
				PD_SETTLING:
				begin
					if (!global_power_down)
					begin
						pd_state <= PD_ACTIVE;
						settle <= 8'h00;
					end
					else if (settle >= PDN_SETTLE[7:0])
					begin
						pd_state <= PD_COMPLETE;
						power_down_complete <= 1'b1; // R04
					end
					else
						settle <= settle + 8'h01;
				end
				PD_COMPLETE:
				begin
					if (!global_power_down)
					begin
						pd_state <= PD_ACTIVE;
						settle <= 8'h00;
						power_down_complete <= 1'b0;
					end
				end
				default:
				begin
					pd_state <= PD_ACTIVE;
					settle <= 8'h00;
					power_down_complete <= 1'b0;
				end
			endcase
		end
	end

	// oscillator switch: any edge of clock_present opens a transition window
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			on_selected <= 1'b0;
			sw_count <= 8'h00;
			oscillator_switch_state <= 2'h1;
			oscillator_power_status <= 1'b1;
		end
		else if (clock_present != on_selected)
		begin
			oscillator_switch_state <= 2'h0; // R12 R13
			oscillator_power_status <= 1'b1;
			if (sw_count >= SWITCH_TIME[7:0])
			begin
				on_selected <= clock_present;
				sw_count <= 8'h00;
			end
			else
				sw_count <= sw_count + 8'h01;
		end
		else
		begin
			sw_count <= 8'h00;
			oscillator_switch_state <= on_selected ? 2'h0 : 2'h1; // R14
			oscillator_power_status <= ~on_selected; // R14
		end
	end

	// tip debounce: new level must persist for the code's time
	assign tip_level = tip_raw ^ tip_ctl[`BIT_TIP_INV]; // R15
	assign dbnc_code = tip_level ? tip_ctl[2:0] : tip_ctl[5:3]; // R16
	always @*
	begin
		case (dbnc_code)
			3'h0: dbnc_limit = 32'h0;
			3'h1: dbnc_limit = MS_CYCLES * `DBNC_STEP_MS; // R16
			3'h2: dbnc_limit = MS_CYCLES * 250;
			3'h3: dbnc_limit = MS_CYCLES * 500;
			3'h4: dbnc_limit = MS_CYCLES * 750;
			3'h5: dbnc_limit = MS_CYCLES * 1000;
			3'h6: dbnc_limit = MS_CYCLES * 1250;
			default: dbnc_limit = MS_CYCLES * 1500;
		endcase
	end

	// any raw change restarts the count, so a bouncing contact never settles
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tip_seen <= 1'b0;
			dbnc_count <= 32'h0;
			tip_plug_debounced <= 1'b0;
			tip_unplug_debounced <= 1'b0;
		end
		else if (tip_level != tip_seen)
		begin
			tip_seen <= tip_level;
			dbnc_count <= 32'h0;
		end
		else if (dbnc_count >= dbnc_limit)
		begin
			tip_plug_debounced <= tip_seen; // R17
			tip_unplug_debounced <= ~tip_seen; // R17
		end
		else
			dbnc_count <= dbnc_count + 32'h1;
	end

	frame_clock_gen frame_gen (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.enable(hybrid_mode),
		.bit_tick(bit_tick),
		.high_count({fpw_hi[2:0], fpw_lo}), // R21
		.period_count({fper_hi[3:0], fper_lo}), // R22
		.frame_clk(frame_clk)
	);
endmodule
`default_nettype wire

//--- power_clock_control_bank_bench.sv
/* self-checking bench for the power and clock bank;
   assumes the host model carries all register traffic. */
`timescale 1ns/10ps
`default_nettype none
module power_clock_control_bank_bench;
	logic sys_clk, rst_n, host_busy, access_busy, tip_raw, hybrid_mode;
	logic serial_input_interface, reg_wr, reg_rd, latch, bit_tick;
	logic [15:0] reg_addr, a;
	logic [7:0] reg_wdata, reg_rdata, q, r, m, hi, per;
	logic [1:0] s;
	wire sp, mx, hp, rc, mon, clamp, dv, src, frame_clk, use_sel, tmh, tma;
	wire sle;
	wire [7:0] outs = {sp, mx, hp, rc, mon, clamp, dv, src};
	wire [7:0] tmo = {6'h0, tmh, tma};
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	int i;
	// address, reset value, writable mask
	logic [31:0] tab [12] = '{32'h1010b77f, 32'h1101ff69, 32'h1102841a,
		32'h11030004, 32'h11070001, 32'h11131bbf, 32'h12010003,
		32'h120300ff, 32'h12040007, 32'h1205f9ff, 32'h1206000f,
		32'h13000000};
	power_clock_control_bank #(.MS_CYCLES(4)) uut (.sys_clk, .rst_n,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .host_busy,
		.access_busy, .host_timeout(tmh), .access_timeout(tma),
		.latch_to_standby_supply(latch), .tip_raw, .bit_tick,
		.serial_input_interface, .hybrid_mode, .serial_input_power_up(sp),
		.mixer_power_up(mx), .headphone_power_up(hp),
		.rate_converter_power_up(rc), .supply_monitor_power_up(mon),
		.filter_cap_clamp(clamp), .use_selected_clock(use_sel),
		.master_clock_divider(dv), .master_clock_source_select(src),
		.frame_clk, .standby_latch_error(sle));
	host_model host (.sys_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .latch_to_standby_supply(latch), .bit_tick);
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task rchk(input logic [15:0] ad, input logic [7:0] e, input logic [7:0] k);
		host.rd(ad, q);
		cmp(q & k, e);
	endtask
	task finish_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// hang guard, far above the roughly 1500 cycles the run needs
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			finish_test;
		end
	end
	initial
	begin
		rst_n = 1'b0;
		{host_busy, access_busy, tip_raw, hybrid_mode} = 4'h0;
		serial_input_interface = 1'b1;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		cmp(outs, 8'h00);
		cmp({7'h0, sle}, 8'h01);
		for (i = 0; i < 12; i++)
		begin
			{a, r, m} = tab[i];
			rchk(a, r, 8'hff);
			host.wr(a, 8'hff);
			rchk(a, m | r, 8'hff);
			host.wr(a, r);
		end
		$display("register table test done");
		cmp({7'h0, sle}, 8'h00);
		host.wr(16'h1101, 8'h00);
		cmp(outs, 8'hf0);
		host.wr(16'h100a, 8'h02);
		cmp(outs, 8'he0);
		host.wr(16'h1102, 8'h0a);
		cmp(outs, 8'hf0);
		host.wr(16'h1102, 8'h08);
		cmp(outs, 8'he0);
		host.wr(16'h1102, 8'h84);
		host.wr(16'h100a, 8'h00);
		host.wr(16'h1103, 8'h04);
		cmp(outs, 8'hf8);
		host.wr(16'h1103, 8'h00);
		host.wr(16'h1101, 8'h68);
		cmp(outs, 8'h10);
		host.wr(16'h1101, 8'h01);
		cmp(outs, 8'h00);
		repeat (34) @(negedge sys_clk);
		rchk(16'h1309, 8'h01, 8'hff);
		host.wr(16'h1102, 8'h94);
		host.wr(16'h1201, 8'h03);
		cmp(outs, 8'h07);
		host.wr(16'h1201, 8'h00);
		host.wr(16'h1102, 8'h84);
		$display("power test done");
		rchk(16'h1109, 8'h05, 8'hff);
		host.wr(16'h1107, 8'h01);
		rchk(16'h1109, 8'h04, 8'hff);
		repeat (20) @(negedge sys_clk);
		cmp({7'h0, use_sel}, 8'h01);
		rchk(16'h1109, 8'h00, 8'hff);
		host.wr(16'h1107, 8'h00);
		rchk(16'h1109, 8'h04, 8'hff);
		repeat (20) @(negedge sys_clk);
		cmp({7'h0, use_sel}, 8'h00);
		rchk(16'h1109, 8'h05, 8'hff);
		$display("clock switch test done");
		host.wr(16'h1113, 8'h00);
		tip_raw = 1'b1;
		repeat (10) @(negedge sys_clk);
		host.rd(16'h1115, q);
		s = q[3:2];
		cmp({7'h0, ^s}, 8'h01);
		host.wr(16'h1113, 8'h80);
		repeat (10) @(negedge sys_clk);
		rchk(16'h1115, {4'h0, s[0], s[1], 2'h0}, 8'h0c);
		host.wr(16'h1113, 8'h01);
		repeat (490) @(negedge sys_clk);
		rchk(16'h1115, {4'h0, s[0], s[1], 2'h0}, 8'h0c);
		repeat (20) @(negedge sys_clk);
		rchk(16'h1115, {4'h0, s, 2'h0}, 8'h0c);
		$display("tip test done");
		host.wr(16'h1010, 8'h00);
		{host_busy, access_busy} = 2'h3;
		repeat (5) @(negedge sys_clk);
		cmp(tmo, 8'h00);
		repeat (5) @(negedge sys_clk);
		cmp(tmo, 8'h01);
		repeat (240) @(negedge sys_clk);
		cmp(tmo, 8'h01);
		repeat (15) @(negedge sys_clk);
		cmp(tmo, 8'h03);
		{host_busy, access_busy} = 2'h0;
		host.wr(16'h1010, 8'h48);
		{host_busy, access_busy} = 2'h3;
		repeat (300) @(negedge sys_clk);
		cmp(tmo, 8'h00);
		{host_busy, access_busy} = 2'h0;
		$display("timeout test done");
		host.wr(16'h1203, 8'h02);
		host.wr(16'h1205, 8'h05);
		hybrid_mode = 1'b1;
		repeat (2) @(posedge frame_clk);
		@(negedge sys_clk);
		for (hi = 8'h0; frame_clk === 1'b1; hi++)
			@(negedge sys_clk);
		for (per = hi; frame_clk === 1'b0; per++)
			@(negedge sys_clk);
		cmp(hi, 8'h0c);
		cmp(per, 8'h18);
		$display("frame clock test done");
		finish_test;
	end
endmodule
`default_nettype wire

//--- power_clock_map.vh
/*
 * register offsets, field positions, reset values and timing counts for the
 * power and clock control bank; assumes a 16-bit register index and 8-bit data.
 */
// Overview of operation
// (R01) host-access timeout 64/128/256/512 ms by two-bit select, off when disabled.
// (R02) register access timeout 7..511 or 65535 cycles by code, off when disabled.
// (R03) global power-down forces every block off; clearing restores individual settings. Supply monitor and an overridden rate converter ignore it here.
// (R04) power-down-complete flag sets once global power-down has fully taken effect.
// (R05) host enables latch-to-standby-supply before setting global power-down.
// (R06) serial input path powered up at 0, down at 1; clock not tristated.
// (R07) mixer and headphone-with-DAC power-downs act at 1, default powered down.
// (R08) host sets filter clamp only in global power-down; clamp grounds filter node.
// (R09) without override, rate converters off on bypass or power-down, else follow interface.
// (R10) with override, rate converter power follows its dedicated bit, default 0.
// (R11) supply monitor enable powers monitor down at 0, up at 1.
// (R12) clock-present rising starts switch from internal oscillator to selected source.
// (R13) clock-present falling starts switch back to internal oscillator.
// (R14) switch status 00 in transition, 01 on oscillator; oscillator power bit shown.
// (R15) tip invert swaps meaning of debounced plug and unplug bits.
// (R16) three-bit fall and rise debounce codes give 0 ms to 1.5 s.
// (R17) read-only debounced unplug and plug bits read 1 when condition present.
// (R18) divider bit passes source divided by 1 at 0, by 2 at 1.
// (R19) host changes divider bit only during global power-down.
// (R20) source select takes bit clock at 0, PLL output at 1.
// (R21) frame high time is 11-bit value plus one bit clocks.
// (R22) frame period is 12-bit value plus one bit clocks.
// (R23) reserved bits read their defaults; writes to them have no effect.
`ifndef POWER_CLOCK_MAP_VH
`define POWER_CLOCK_MAP_VH
`define ADDR_TIMEOUT 16'h1010
`define ADDR_PDN1 16'h1101
`define ADDR_PDN2 16'h1102
`define ADDR_PDN3 16'h1103
`define ADDR_OSC_CTL 16'h1107
`define ADDR_OSC_STAT 16'h1109
`define ADDR_TIP_CTL 16'h1113
`define ADDR_TIP_STAT 16'h1115
`define ADDR_MCLK_SRC 16'h1201
`define ADDR_FPW_LO 16'h1203
`define ADDR_FPW_HI 16'h1204
`define ADDR_FPER_LO 16'h1205
`define ADDR_FPER_HI 16'h1206
`define ADDR_SRC_CTL 16'h100a
`define ADDR_POWER_DOWN_COMPLETE 16'h1309
`define RST_TIMEOUT 8'hb7
`define RST_PDN1 8'hff
`define RST_PDN2 8'h84
`define RST_PDN3 8'h00
`define RST_FPER_LO 8'hf9
`define RST_TIP_CTL 8'h1b
`define MASK_TIMEOUT 8'h7f
`define MASK_PDN1 8'h69
`define MASK_PDN2 8'h1a
`define MASK_PDN3 8'h04
`define MASK_TIP_CTL 8'hbf
`define MASK_MCLK_SRC 8'h03
`define MASK_FPW_HI 8'h07
`define MASK_FPER_HI 8'h0f
`define BIT_GLOBAL_POWER_DOWN 0
`define BIT_HEADPHONE_POWER_DOWN 3
`define BIT_MIX_PDN 5
`define BIT_SER_PDN 6
`define BIT_RC_ON 1
`define BIT_RC_OVR 3
`define BIT_CLAMP 4
`define BIT_MON_EN 2
`define BIT_TIP_INV 7
`define CLK_HZ 40000000
`define MS_BASE 64
`define SWITCH_CYCLES 16
`define PDN_SETTLE_CYCLES 32
`define DBNC_STEP_MS 125
`endif

//--- timeout_counter.v
/*
 * one timeout counter: counts while armed, flags when limit reached.
 * assumes limit is held steady while armed.
 */
`timescale 1ns/10ps
`default_nettype none
module timeout_counter #(
	parameter W = 32
)(
	input wire sys_clk,
	input wire rst_n,
	input wire arm,
	input wire [W-1:0] limit,
	output reg expired
);
	reg [W-1:0] count;
	// restart on every disarm so each access gets the full window
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= {W{1'b0}};
			expired <= 1'b0;
		end
		else if (!arm)
		begin
			count <= {W{1'b0}};
			expired <= 1'b0;
		end
		else if (count >= limit)
			expired <= 1'b1;
		else
			count <= count + {{(W-1){1'b0}}, 1'b1};
	end
endmodule
`default_nettype wire
